/* logic/drx_top.sv */
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "drx_defines.svh"

module drx_top #(
   parameter logic [27:0] NATIVE_MAX_LBA  = 28'h0FFFFFF,
   parameter logic [15:0] NATIVE_MAX_CYL  = 16'h3FFF,
   parameter logic [3:0]  NATIVE_MAX_HEAD = 4'hF,
   parameter logic [7:0]  NATIVE_MAX_SECT = 8'h3F
) (
   // Clock and reset
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   // APB slave
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [7:0]              paddr,
   input  wire logic [31:0]             pwdata,
   output logic                         pready,
   output logic [31:0]                  prdata,
   output logic                         pslverr,
   // Media engine
   output drx_pkg::drx_media_req_t      media_req,
   output logic                         media_word_ready,
   input  wire drx_pkg::drx_media_rsp_t media_rsp,
   // Interrupt
   output logic                         irq
);
   import drx_pkg::*;

   drx_state_t  state;
   logic [7:0]  feature_select;
   logic [7:0]  error_flags;
   logic [7:0]  sector_count;
   logic [7:0]  sector_number;
   logic [7:0]  cylinder_low_byte;
   logic [7:0]  cylinder_high_byte;
   logic [7:0]  drive_head_select;
   logic [7:0]  drive_status;
   logic        is_slave;
   logic [15:0] word_transfer_port;
   logic        word_full;
   logic        data_armed;
   logic [8:0]  remaining;
   logic        cmd_verify;
   logic [2:0]  irq_status;
   logic [2:0]  irq_mask;

   logic        xfer;
   logic        wr_en;
   logic        rd_en;
   logic        busy;
   logic        selected;
   logic        cmd_write;
   logic [7:0]  op;
   logic        tf_write;
   logic        data_pop;
   logic        word_take;
   logic        next_word_full;
   logic        ev_done;
   logic        ev_err;
   logic        ev_drq;
   logic        lba_mode;
   drx_addr_t   cur_addr;
   drx_addr_t   adv_addr;
   logic [2:0]  irq_clear;

   // Step one sector forward in the current addressing mode
   function automatic drx_addr_t next_addr(input drx_addr_t a, input logic lba);
      drx_addr_t   r;
      logic [27:0] l;
      r = a;
      l = {a.head, a.cyl, a.sector};
      if (lba) begin
         l = l + 28'h0000001;
         r = '{head: l[27:24], cyl: l[23:8], sector: l[7:0]};
      end else if (a.sector < NATIVE_MAX_SECT) begin
         r.sector = a.sector + 8'h01;
      end else begin
         r.sector = 8'h01;
         if (a.head < NATIVE_MAX_HEAD) begin
            r.head = a.head + 4'h1;
         end else begin
            r.head = 4'h0;
            r.cyl  = a.cyl + 16'h0001;
         end
      end
      return r;
   endfunction

   assign xfer      = psel & penable & pready;
   assign wr_en     = xfer & pwrite;
   assign rd_en     = xfer & ~pwrite;
   assign busy      = (state != DRX_IDLE);
   assign lba_mode  = drive_head_select[`DRX_DH_LBA];
   assign selected  = (drive_head_select[`DRX_DH_DEV] == is_slave);
   assign op        = pwdata[7:0] & `DRX_OP_RETRY_MASK;
   assign cmd_write = wr_en & (paddr == `DRX_OFS_CMD_STAT) & ~busy & selected;
   assign tf_write  = wr_en & ~busy;
   assign data_pop  = rd_en & (paddr == `DRX_OFS_DATA) & data_armed;
   assign word_take = media_rsp.word_valid & media_word_ready & ~cmd_verify
                      & (state == DRX_WAIT);
   assign cur_addr  = '{head: drive_head_select[3:0],
                        cyl: {cylinder_high_byte, cylinder_low_byte},
                        sector: sector_number};
   assign adv_addr  = next_addr(cur_addr, lba_mode);

   // A failing sector's word still in the holding register is dropped and no longer raises DRQ
   always_comb begin
      next_word_full = word_full;
      if (data_pop) begin
         next_word_full = 1'b0;
      end
      if (word_take) begin
         next_word_full = 1'b1;
      end
      if (state == DRX_WAIT && media_rsp.uncorrectable) begin
         next_word_full = 1'b0;
      end
   end

   assign ev_drq  = word_take;
   assign ev_err  = (state == DRX_WAIT) & media_rsp.uncorrectable;
   assign ev_done = ev_err | ((state == DRX_DRAIN) & ~next_word_full)
                    | ((state == DRX_WAIT) & cmd_verify & media_rsp.sector_done
                       & ~media_rsp.uncorrectable & (remaining == 9'h001))
                    | (cmd_write & ~(op == `DRX_OP_READ || op == `DRX_OP_VERIFY));
   // Clear only the bits that the read showed; an event in its wait state survives
   assign irq_clear = (rd_en && paddr == `DRX_OFS_IRQ_STAT) ? prdata[2:0] : 3'h0;

   // APB slave: one wait state so every answer comes from a flip-flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         if (psel & penable & ~pready) begin
            case (paddr)
               `DRX_OFS_DATA:     prdata <= {16'h0000, word_transfer_port};
               `DRX_OFS_FEAT_ERR: prdata <= {24'h000000, error_flags};
               `DRX_OFS_SCOUNT:   prdata <= {24'h000000, sector_count};
               `DRX_OFS_SNUM:     prdata <= {24'h000000, sector_number};
               `DRX_OFS_CYL_LO:   prdata <= {24'h000000, cylinder_low_byte};
               `DRX_OFS_CYL_HI:   prdata <= {24'h000000, cylinder_high_byte};
               `DRX_OFS_DEVHEAD:  prdata <= {24'h000000, drive_head_select};
               `DRX_OFS_CMD_STAT: prdata <= {24'h000000, drive_status};
               `DRX_OFS_CONFIG:   prdata <= {31'h00000000, is_slave};
               `DRX_OFS_IRQ_STAT: prdata <= {29'h00000000, irq_status};
               `DRX_OFS_IRQ_MASK: prdata <= {29'h00000000, irq_mask};
               default:           pslverr <= 1'b1;
            endcase
         end
      end
   end

   // Configuration and interrupt mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         is_slave <= 1'b0;
         irq_mask <= `DRX_RST_IRQ;
      end else if (wr_en) begin
         if (paddr == `DRX_OFS_CONFIG) begin
            is_slave <= pwdata[0];
         end
         if (paddr == `DRX_OFS_IRQ_MASK) begin
            irq_mask <= pwdata[2:0];
         end
      end
   end

   // Sticky events; a new event wins over the read that clears it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= `DRX_RST_IRQ;
         irq         <= 1'b0;
      end else begin
         irq_status <= (irq_status & ~irq_clear) | {ev_drq, ev_err, ev_done};
         irq        <= |(irq_status & irq_mask);
      end
   end

   // Host write of the feature byte; unused by these commands
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         feature_select <= `DRX_RST_BYTE;
      end else if (tf_write && paddr == `DRX_OFS_FEAT_ERR) begin
         feature_select <= pwdata[7:0];
      end
   end

   // A read pops only the word that its wait state showed in prdata,
   // so a word landing in that wait state is kept for the next read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_armed <= 1'b0;
      end else begin
         data_armed <= psel & penable & ~pready & ~pwrite & (paddr == `DRX_OFS_DATA)
                       & word_full;
      end
   end

   // Word holding register toward the host
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word_transfer_port <= 16'h0000;
         word_full          <= 1'b0;
         media_word_ready   <= 1'b0;
      end else begin
         if (word_take) begin
            word_transfer_port <= media_rsp.word;
         end
         word_full        <= next_word_full;
         // Registered ready: a word may arrive only while the register stays free
         media_word_ready <= ~next_word_full & ~word_take & ~data_pop;
      end
   end

   // Command sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state      <= DRX_IDLE;
         remaining  <= 9'h000;
         cmd_verify <= 1'b0;
         media_req  <= '0;
      end else begin
         media_req.req <= 1'b0;
         case (state)
            DRX_IDLE: begin
               if (cmd_write && op == `DRX_OP_READ) begin
                  cmd_verify <= 1'b0;
                  state      <= DRX_ISSUE;
               end else if (cmd_write && op == `DRX_OP_VERIFY) begin
                  cmd_verify <= 1'b1;
                  state      <= DRX_ISSUE;
               end
               if (cmd_write) begin
                  remaining <= (sector_count == 8'h00) ? `DRX_FULL_COUNT
                                                       : {1'b0, sector_count};
               end
            end
            DRX_ISSUE: begin
               // A read waits until the host has emptied the holding register, so an
               // error can only discard words of the failing sector, never a good one
               if (cmd_verify || !word_full) begin
                  media_req <= '{req: 1'b1, verify: cmd_verify, lba_mode: lba_mode,
                                 head: cur_addr.head, cyl: cur_addr.cyl,
                                 sector: cur_addr.sector};
                  state     <= DRX_WAIT;
               end
            end
            DRX_WAIT: begin
               if (media_rsp.uncorrectable) begin
                  state <= DRX_IDLE;
               end else if (media_rsp.sector_done) begin
                  remaining <= remaining - 9'h001;
                  if (remaining == 9'h001) begin
                     state <= cmd_verify ? DRX_IDLE : DRX_DRAIN;
                  end else begin
                     state <= DRX_ISSUE;
                  end
               end
            end
            DRX_DRAIN: begin
               if (!next_word_full) begin
                  state <= DRX_IDLE;
               end
            end
            default: state <= DRX_IDLE;
         endcase
      end
   end

   // Task file: host writes, address stepping and result loading
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sector_count       <= `DRX_RST_BYTE;
         sector_number      <= `DRX_RST_BYTE;
         cylinder_low_byte  <= `DRX_RST_BYTE;
         cylinder_high_byte <= `DRX_RST_BYTE;
         drive_head_select  <= `DRX_RST_DEVHEAD;
      end else begin
         if (tf_write) begin
            case (paddr)
               `DRX_OFS_SCOUNT:  sector_count       <= pwdata[7:0];
               `DRX_OFS_SNUM:    sector_number      <= pwdata[7:0];
               `DRX_OFS_CYL_LO:  cylinder_low_byte  <= pwdata[7:0];
               `DRX_OFS_CYL_HI:  cylinder_high_byte <= pwdata[7:0];
               `DRX_OFS_DEVHEAD: drive_head_select  <= pwdata[7:0];
               default: ;
            endcase
         end
         // Native maximum comes from fixed geometry, never from a host limit
         if (cmd_write && op == `DRX_OP_NATIVE_MAX) begin
            if (lba_mode) begin
               sector_number          <= NATIVE_MAX_LBA[7:0];
               cylinder_low_byte      <= NATIVE_MAX_LBA[15:8];
               cylinder_high_byte     <= NATIVE_MAX_LBA[23:16];
               drive_head_select[3:0] <= NATIVE_MAX_LBA[27:24];
            end else begin
               sector_number          <= NATIVE_MAX_SECT;
               cylinder_low_byte      <= NATIVE_MAX_CYL[7:0];
               cylinder_high_byte     <= NATIVE_MAX_CYL[15:8];
               drive_head_select[3:0] <= NATIVE_MAX_HEAD;
            end
         end
         // On error the address stays on the failing sector
         if (state == DRX_WAIT && !media_rsp.uncorrectable && media_rsp.sector_done) begin
            sector_count <= 8'(remaining - 9'h001);
            if (remaining != 9'h001) begin
               sector_number          <= adv_addr.sector;
               cylinder_low_byte      <= adv_addr.cyl[7:0];
               cylinder_high_byte     <= adv_addr.cyl[15:8];
               drive_head_select[3:0] <= adv_addr.head;
            end
         end
         if (ev_err) begin
            sector_count <= 8'(remaining);
         end
      end
   end

   // Status and error registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_status <= `DRX_RST_STATUS;
         error_flags  <= `DRX_RST_BYTE;
      end else begin
         drive_status[`DRX_ST_BSY] <= busy & ~next_word_full & ~ev_done;
         drive_status[`DRX_ST_RDY] <= 1'b1;
         drive_status[`DRX_ST_DF]  <= 1'b0;
         drive_status[`DRX_ST_DSC] <= 1'b1;
         drive_status[`DRX_ST_DRQ] <= next_word_full;
         drive_status[2:1]         <= 2'h0;
         if (cmd_write) begin
            error_flags               <= `DRX_RST_BYTE;
            drive_status[`DRX_ST_ERR] <= 1'b0;
            drive_status[`DRX_ST_BSY] <= (op == `DRX_OP_READ) || (op == `DRX_OP_VERIFY);
            if (op != `DRX_OP_READ && op != `DRX_OP_VERIFY && op != `DRX_OP_NATIVE_MAX) begin
               error_flags[`DRX_ER_ABT]  <= 1'b1;
               drive_status[`DRX_ST_ERR] <= 1'b1;
            end
         end
         if (ev_err) begin
            error_flags[`DRX_ER_UNC]  <= 1'b1;
            drive_status[`DRX_ST_ERR] <= 1'b1;
         end
      end
   end

endmodule

/* logic/drx_defines.svh */
`ifndef DRX_DEFINES_SVH
`define DRX_DEFINES_SVH

// APB byte offsets
`define DRX_OFS_DATA       8'h00
`define DRX_OFS_FEAT_ERR   8'h04
`define DRX_OFS_SCOUNT     8'h08
`define DRX_OFS_SNUM       8'h0C
`define DRX_OFS_CYL_LO     8'h10
`define DRX_OFS_CYL_HI     8'h14
`define DRX_OFS_DEVHEAD    8'h18
`define DRX_OFS_CMD_STAT   8'h1C
`define DRX_OFS_CONFIG     8'h20
`define DRX_OFS_IRQ_STAT   8'h24
`define DRX_OFS_IRQ_MASK   8'h28

// Device/head fields
`define DRX_DH_LBA         6
`define DRX_DH_DEV         4

// Status fields
`define DRX_ST_BSY         7
`define DRX_ST_RDY         6
`define DRX_ST_DF          5
`define DRX_ST_DSC         4
`define DRX_ST_DRQ         3
`define DRX_ST_ERR         0

// Error fields
`define DRX_ER_UNC         6
`define DRX_ER_ABT         2

// Interrupt status fields
`define DRX_IRQ_DONE       0
`define DRX_IRQ_ERR        1
`define DRX_IRQ_DRQ        2
`define DRX_IRQ_W          3

// Opcodes with the retry bit masked off
`define DRX_OP_READ        8'h20
`define DRX_OP_VERIFY      8'h40
`define DRX_OP_NATIVE_MAX  8'hF8
`define DRX_OP_RETRY_MASK  8'hFE

// Reset values
`define DRX_RST_STATUS     8'h50
`define DRX_RST_BYTE       8'h00
`define DRX_RST_DEVHEAD    8'hA0
`define DRX_RST_IRQ        3'h0

// Sector count zero stands for this many sectors
`define DRX_FULL_COUNT     9'h100

`endif

/* logic/drx_pkg.sv */
package drx_pkg;

   typedef enum logic [2:0] {
      DRX_IDLE,
      DRX_ISSUE,
      DRX_WAIT,
      DRX_DRAIN
   } drx_state_t;

   // Request to the media engine: one sector at the given address
   typedef struct packed {
      logic        req;
      logic        verify;
      logic        lba_mode;
      logic [3:0]  head;
      logic [15:0] cyl;
      logic [7:0]  sector;
   } drx_media_req_t;

   // Answer from the media engine
   typedef struct packed {
      logic        word_valid;
      logic [15:0] word;
      logic        sector_done;
      logic        uncorrectable;
   } drx_media_rsp_t;

   typedef struct packed {
      logic [3:0]  head;
      logic [15:0] cyl;
      logic [7:0]  sector;
   } drx_addr_t;

endpackage

/* testbench/drx_sva.sv */
`timescale 1ns/1ps
`include "drx_defines.svh"
module drx_sva (
   // Clock and reset
   input wire logic                    pclk,
   input wire logic                    presetn,
   // APB
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [7:0]              paddr,
   input wire logic [31:0]             pwdata,
   input wire logic                    pready,
   input wire logic [31:0]             prdata,
   input wire logic                    pslverr,
   // Media
   input wire drx_pkg::drx_media_req_t media_req,
   input wire drx_pkg::drx_media_rsp_t media_rsp
);
   import drx_pkg::*;
   logic       acc_wr;
   logic       cmd_wr;
   logic       nat_wr;
   logic       dev_ok;
   logic [7:0] dh;
   logic [7:0] sn;
   logic       cfg;
   assign acc_wr = psel && penable && pready && pwrite;
   assign nat_wr = acc_wr && paddr == `DRX_OFS_CMD_STAT && pwdata[7:0] == `DRX_OP_NATIVE_MAX;
   assign cmd_wr = acc_wr && paddr == `DRX_OFS_CMD_STAT
                   && (pwdata[7:0] & `DRX_OP_RETRY_MASK) inside {`DRX_OP_READ, `DRX_OP_VERIFY};
   assign dev_ok = dh[`DRX_DH_DEV] == cfg;
   // Shadow of host writes; valid because the bench never writes while busy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dh <= `DRX_RST_DEVHEAD;
         sn <= 8'h00;
         cfg <= 1'b0;
      end else if (acc_wr) begin
         if (paddr == `DRX_OFS_DEVHEAD) dh <= pwdata[7:0];
         if (paddr == `DRX_OFS_SNUM) sn <= pwdata[7:0];
         if (paddr == `DRX_OFS_CONFIG) cfg <= pwdata[0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_cmd_req;
      cmd_wr && dev_ok |-> ##2 media_req.req && media_req.verify == $past(pwdata[6], 2);
   endproperty
   a_cmd_req: assert property (p_cmd_req) else $error("missing media request");
   property p_refused;
      cmd_wr && !dev_ok |=> !media_req.req [*3];
   endproperty
   a_refused: assert property (p_refused) else $error("other drive acted");
   property p_native;
      nat_wr |=> !media_req.req [*3];
   endproperty
   a_native: assert property (p_native) else $error("native max touched media");
   property p_unc_stop;
      media_rsp.uncorrectable |=> !media_req.req [*8];
   endproperty
   a_unc_stop: assert property (p_unc_stop) else $error("sector after error");
   property p_lba;
      cmd_wr && dev_ok |-> ##2 media_req.lba_mode == $past(dh[`DRX_DH_LBA], 2);
   endproperty
   a_lba: assert property (p_lba) else $error("wrong addressing mode");
   property p_first;
      cmd_wr && dev_ok |-> ##2 media_req.sector == $past(sn, 2);
   endproperty
   a_first: assert property (p_first) else $error("wrong first sector");
   property p_data16;
      pready && !pwrite && paddr == `DRX_OFS_DATA |-> prdata[31:16] == 16'h0000;
   endproperty
   a_data16: assert property (p_data16) else $error("data wider than a word");
   property p_pulse;
      media_req.req |=> !media_req.req;
   endproperty
   a_pulse: assert property (p_pulse) else $error("request held");
   c_cmd: cover property (cmd_wr && dev_ok);
   c_unc: cover property (media_rsp.uncorrectable);
   c_err: cover property (pslverr);
endmodule

bind drx_top drx_sva u_sva (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .media_req(media_req), .media_rsp(media_rsp));

/* testbench/drx_media_model.sv */
`timescale 1ns/1ps
module drx_media_model (
   // Clock and reset
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   // Design side
   input  wire drx_pkg::drx_media_req_t media_req,
   input  wire logic                    media_word_ready,
   output drx_pkg::drx_media_rsp_t      media_rsp,
   // Fault control
   input  wire logic                    fail_en,
   input  wire logic [7:0]              fail_sector
);
   import drx_pkg::*;
   logic       busy;
   logic [2:0] left;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy <= 1'b0;
         left <= 3'd0;
         media_rsp <= '0;
      end else begin
         media_rsp.sector_done <= 1'b0;
         media_rsp.uncorrectable <= 1'b0;
         // An idle bus inverts every bit of the word on each cycle
         if (!media_rsp.word_valid) media_rsp.word <= ~media_rsp.word;
         if (media_req.req) begin
            busy <= 1'b1;
            left <= media_req.verify ? 3'd0 : 3'd2;
         end else if (busy && fail_en && media_req.sector == fail_sector) begin
            busy <= 1'b0;
            media_rsp.uncorrectable <= 1'b1;
         end else if (busy && left == 3'd0) begin
            busy <= 1'b0;
            media_rsp.sector_done <= 1'b1;
         end else if (busy && !media_rsp.word_valid) begin
            media_rsp.word_valid <= 1'b1;
            media_rsp.word <= {left, 5'h00, media_req.sector};
         end else if (media_rsp.word_valid && media_word_ready) begin
            media_rsp.word_valid <= 1'b0;
            left <= left - 3'd1;
         end
      end
   end
endmodule

/* testbench/disk_read_command_executor_tb.sv */
`timescale 1ns/1ps
`include "drx_defines.svh"
module disk_read_command_executor_tb;
   import drx_pkg::*;
   localparam logic [27:0] MLBA = 28'h5ABCD12;
   localparam logic [15:0] MCYL = 16'h1234;
   localparam logic [3:0]  MHD  = 4'h9;
   localparam logic [7:0]  MSC  = 8'h21;
   logic           pclk;
   logic           presetn;
   logic           psel;
   logic           penable;
   logic           pwrite;
   logic [7:0]     paddr;
   logic [31:0]    pwdata;
   logic [31:0]    prdata;
   logic           pready;
   logic           pslverr;
   logic           irq;
   logic           mwr;
   logic           fail_en;
   logic [7:0]     fail_sec;
   logic           last_err;
   drx_media_req_t mreq;
   drx_media_rsp_t mrsp;
   logic [15:0]    exp_q[$];
   int             num_errors = 0;
   int             tests_run = 0;
   drx_top #(.NATIVE_MAX_LBA(MLBA), .NATIVE_MAX_CYL(MCYL), .NATIVE_MAX_HEAD(MHD),
      .NATIVE_MAX_SECT(MSC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .media_req(mreq), .media_word_ready(mwr),
      .media_rsp(mrsp), .irq(irq));
   drx_media_model u_media (.pclk(pclk), .presetn(presetn), .media_req(mreq),
      .media_word_ready(mwr), .media_rsp(mrsp), .fail_en(fail_en), .fail_sector(fail_sec));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   task automatic stop_test();
      $display("%0d checks, %0d mismatches", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         num_errors++;
         stop_test();
      end
      r = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      apb(1'b1, a, {24'h0, d}, r);
   endtask
   task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e);
      logic [31:0] r;
      apb(1'b0, a, 32'h0, r);
      chk(nm, {24'h0, e}, r);
   endtask
   task automatic setup(input logic [7:0] sc, sn, cl, ch, dh);
      wr(`DRX_OFS_SCOUNT, sc);
      wr(`DRX_OFS_SNUM, sn);
      wr(`DRX_OFS_CYL_LO, cl);
      wr(`DRX_OFS_CYL_HI, ch);
      wr(`DRX_OFS_DEVHEAD, dh);
   endtask
   // Issue a command and serve the drive until busy drops
   task automatic cmd(input logic [7:0] op);
      logic [31:0] r;
      int n;
      wr(`DRX_OFS_CMD_STAT, op);
      for (n = 0; n < 4000; n++) begin
         apb(1'b0, `DRX_OFS_CMD_STAT, 32'h0, r);
         if (r[`DRX_ST_DRQ] === 1'b1) begin
            apb(1'b0, `DRX_OFS_DATA, 32'h0, r);
            chk("data", exp_q.size() > 0 ? {16'h0, exp_q.pop_front()} : 32'hFFFF_FFFF, r);
         end else if (r[`DRX_ST_BSY] === 1'b0) break;
      end
      if (n >= 4000) begin
         num_errors++;
         stop_test();
      end
      chk("words left", 32'h0, exp_q.size());
   endtask
   task automatic pushs(input logic [7:0] s, input int cnt);
      for (int i = 0; i < cnt; i++) begin
         exp_q.push_back({3'd2, 5'h00, s + 8'(i)});
         exp_q.push_back({3'd1, 5'h00, s + 8'(i)});
      end
   endtask
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      fail_en = 1'b0;
      fail_sec = 8'h00;
      presetn = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rc("status", `DRX_OFS_CMD_STAT, `DRX_RST_STATUS);
      rc("devhead", `DRX_OFS_DEVHEAD, `DRX_RST_DEVHEAD);
      rc("unmapped", 8'h2C, 8'h00);
      chk("slverr", 32'h1, {31'h0, last_err});
      $display("reset test done");
      setup(8'h07, 8'h00, 8'h00, 8'h00, 8'hE0);
      cmd(`DRX_OP_NATIVE_MAX);
      rc("lba lo", `DRX_OFS_SNUM, MLBA[7:0]);
      rc("lba mid", `DRX_OFS_CYL_LO, MLBA[15:8]);
      rc("lba hi", `DRX_OFS_CYL_HI, MLBA[23:16]);
      rc("lba top", `DRX_OFS_DEVHEAD, {4'hE, MLBA[27:24]});
      wr(`DRX_OFS_DEVHEAD, 8'hA0);
      cmd(8'hF9);
      rc("max sect", `DRX_OFS_SNUM, MSC);
      rc("max cyl lo", `DRX_OFS_CYL_LO, MCYL[7:0]);
      rc("max cyl hi", `DRX_OFS_CYL_HI, MCYL[15:8]);
      rc("max head", `DRX_OFS_DEVHEAD, {4'hA, MHD});
      rc("irq done", `DRX_OFS_IRQ_STAT, 8'h01);
      $display("native max test done");
      wr(`DRX_OFS_IRQ_MASK, 8'h01);
      setup(8'h02, 8'h10, 8'h00, 8'h00, 8'hE0);
      pushs(8'h10, 2);
      cmd(8'h21);
      rc("rd count", `DRX_OFS_SCOUNT, 8'h00);
      rc("rd last", `DRX_OFS_SNUM, 8'h11);
      rc("rd status", `DRX_OFS_CMD_STAT, 8'h50);
      chk("irq on", 32'h1, {31'h0, irq});
      rc("irq stat", `DRX_OFS_IRQ_STAT, 8'h05);
      @(posedge pclk);
      chk("irq off", 32'h0, {31'h0, irq});
      $display("read test done");
      wr(`DRX_OFS_IRQ_MASK, 8'h00);
      fail_en <= 1'b1;
      fail_sec <= 8'h21;
      setup(8'h03, 8'h20, 8'h00, 8'h00, 8'hE0);
      pushs(8'h20, 1);
      cmd(8'h20);
      rc("err count", `DRX_OFS_SCOUNT, 8'h02);
      rc("err last", `DRX_OFS_SNUM, 8'h21);
      rc("err status", `DRX_OFS_CMD_STAT, 8'h51);
      rc("err flags", `DRX_OFS_FEAT_ERR, 8'h40);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(`DRX_OFS_IRQ_MASK, 8'h02);
      @(posedge pclk);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      $display("read error test done");
      fail_en <= 1'b0;
      setup(8'h00, 8'h10, 8'h00, 8'h00, 8'hE0);
      cmd(`DRX_OP_VERIFY);
      rc("vf count", `DRX_OFS_SCOUNT, 8'h00);
      rc("vf last lo", `DRX_OFS_SNUM, 8'h0F);
      rc("vf last mid", `DRX_OFS_CYL_LO, 8'h01);
      rc("vf irq", `DRX_OFS_IRQ_STAT, 8'h07);
      fail_en <= 1'b1;
      fail_sec <= 8'h32;
      setup(8'h04, 8'h30, 8'h00, 8'h00, 8'hE0);
      cmd(8'h41);
      rc("vf err count", `DRX_OFS_SCOUNT, 8'h02);
      rc("vf err last", `DRX_OFS_SNUM, 8'h32);
      rc("vf err status", `DRX_OFS_CMD_STAT, 8'h51);
      $display("verify test done");
      fail_en <= 1'b0;
      setup(8'h02, MSC, 8'h05, 8'h00, 8'hA0);
      cmd(`DRX_OP_VERIFY);
      rc("chs sect", `DRX_OFS_SNUM, 8'h01);
      rc("chs cyl", `DRX_OFS_CYL_LO, 8'h05);
      rc("chs head", `DRX_OFS_DEVHEAD, 8'hA1);
      $display("chs test done");
      setup(8'h01, 8'h10, 8'h00, 8'h00, 8'hF0);
      wr(`DRX_OFS_CMD_STAT, `DRX_OP_READ);
      rc("other status", `DRX_OFS_CMD_STAT, 8'h50);
      rc("other count", `DRX_OFS_SCOUNT, 8'h01);
      wr(`DRX_OFS_CONFIG, 8'h01);
      cmd(`DRX_OP_VERIFY);
      rc("slave count", `DRX_OFS_SCOUNT, 8'h00);
      $display("select test done");
      stop_test();
   end
endmodule
